/* File: common/fcc_pkg.sv */
// constants and types shared by the flash command controller
package fcc_pkg;

	// -----------------------------------------------------------------
	// register addresses
	// -----------------------------------------------------------------
	localparam logic [11:0] FCC_ADDR_COMMAND = 12'hff8;
	localparam logic [11:0] FCC_ADDR_PAGE    = 12'hff9;

	// -----------------------------------------------------------------
	// command codes
	// -----------------------------------------------------------------
	localparam logic [7:0] FCC_CMD_UNLOCK1   = 8'h73;
	localparam logic [7:0] FCC_CMD_UNLOCK2   = 8'h8c;
	localparam logic [7:0] FCC_CMD_PAGE_ERS  = 8'h95;
	localparam logic [7:0] FCC_CMD_MASS_ERS  = 8'h63;
	localparam logic [7:0] FCC_CMD_PROT_SEL  = 8'h5e;

	// -----------------------------------------------------------------
	// state field codes
	// -----------------------------------------------------------------
	localparam logic [5:0] FCC_ST_LOCKED   = 6'h00;
	localparam logic [5:0] FCC_ST_FIRST    = 6'h01;
	localparam logic [5:0] FCC_ST_SECOND   = 6'h02;
	localparam logic [5:0] FCC_ST_UNLOCKED = 6'h03;
	localparam logic [5:0] FCC_ST_PROT     = 6'h04;
	localparam logic [5:0] FCC_ST_PROG     = 6'h08;
	localparam logic [5:0] FCC_ST_PAGE_ERS = 6'h10;
	localparam logic [5:0] FCC_ST_MASS_ERS = 6'h20;

	// -----------------------------------------------------------------
	// field layout and reset values
	// -----------------------------------------------------------------
	localparam int          FCC_INFO_BIT    = 7;
	localparam int          FCC_PAGE_MSB    = 6;
	localparam int          FCC_PAGE_LSB_A  = 9;
	localparam int          FCC_ADDR_MSB    = 15;
	localparam int          FCC_SECT_MSB_A  = 12;
	localparam int          FCC_SECT_LSB_A  = 10;
	localparam logic [7:0]  FCC_RST_BYTE    = 8'h00;
	localparam logic [1:0]  FCC_RSVD_BITS   = 2'h0;
	localparam logic [15:0] FCC_INFO_BASE   = 16'hfe00;
	localparam logic [15:0] FCC_USER_TOP    = 16'h2000;
	localparam logic [15:0] FCC_RSVD_TOP    = 16'h3000;

	// one-hot controller states
	typedef enum logic [7:0] {
		FCC_LOCKED   = 8'h01,
		FCC_FIRST    = 8'h02,
		FCC_SECOND   = 8'h04,
		FCC_UNLOCKED = 8'h08,
		FCC_PROT     = 8'h10,
		FCC_PROG     = 8'h20,
		FCC_PG_ERS   = 8'h40,
		FCC_MS_ERS   = 8'h80
	} fcc_state_t;

endpackage : fcc_pkg

/* File: core/fcc_flash_command_controller.sv */
// command, status, page choice and protection front end of the flash controller
// What this block does
// RQ1: debugger access ignores the write-protect option bit.
// RQ2: debugger access ignores sector protection for program and erase.
// RQ3: debugger may program any address, not only the chosen page.
// RQ4: debugger may set or clear any sector protection bit.
// RQ5: debugger unlock needs no repeated page choice write.
// RQ6: debugger may write page choice while unlocked.
// RQ7: whole-array erase command only honoured from debugger.
// RQ8: software opens one page per unlock, re-unlocks for another, except that a page choice write during programming switches the open page.
// RQ9: user code reaches lower 8KB only; upper 4KB reserved.
// RQ10: reserved code may access reserved region; user code is blocked.
// RQ11: unlock is 73h then 8Ch as consecutive command writes.
// RQ12: invalid command or order returns controller to locked.
// RQ13: third command: 95h page erase, 63h mass erase; 5Eh protect access is taken from locked.
// RQ14: command writes and status reads share address FF8h.
// RQ15: state field encodes locked, first, second, unlocked, protect select.
// RQ16: state reads 001xxx program, 010xxx page erase, 100xxx mass erase.
// RQ17: status bits 7 and 6 read zero.
// RQ18: FF9h writes page choice, or sector protect after locked plus 5Eh.
// RQ19: 512-byte pages; page field matches address bits 15 to 9.
// RQ20: page choice bit 7 maps information area at FE00h-FFFFh.
// RQ21: command, status and page choice reset to zero, locked.
// RQ22: user unlock needs matching page choice rewrite, mismatch relocks.
// RQ23: user writes to sector protection only set bits.
// RQ24: erase completion returns controller to locked.
// RQ25: relaxed behaviour only while debugger access input is asserted.
`timescale 1ns/1ps
`default_nettype none

module fcc_flash_command_controller
	import fcc_pkg::*;
#(
	parameter int SECTOR_BITS = 8
)(
	// clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_n_in,
	// register file port
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic [11:0]            reg_addr_in,
	input  wire logic [7:0]             reg_wdata_in,
	output logic      [7:0]             reg_rdata_out,
	// access origin
	input  wire logic                   debug_access_in,
	input  wire logic                   fetch_reserved_in,
	input  wire logic                   write_protect_opt_in,
	// program memory access check
	input  wire logic                   mem_req_in,
	input  wire logic                   mem_wr_in,
	input  wire logic [15:0]            mem_addr_in,
	output logic                        mem_grant_out,
	output logic                        mem_prog_out,
	output logic                        info_area_select_out,
	output logic [SECTOR_BITS-1:0]      sector_protect_out,
	// flash array sequencing
	input  wire logic                   op_done_in,
	input  wire logic [2:0]             op_sector_in,
	output logic                        page_erase_start_out,
	output logic                        mass_erase_start_out,
	output logic [6:0]                  active_page_out
);

	// -----------------------------------------------------------------
	// state and registers
	// -----------------------------------------------------------------
	fcc_state_t                 state_q, state_d;
	logic [7:0]                 page_choice_q, page_choice_d;
	logic [SECTOR_BITS-1:0]     protect_q, protect_d;
	logic                       mass_ok_q, mass_ok_d;
	logic                       pg_start_q, ms_start_q;
	logic                       pg_start_d, ms_start_d;

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	wire logic cmd_wr    = reg_wr_in && (reg_addr_in == FCC_ADDR_COMMAND);
	wire logic page_wr   = reg_wr_in && (reg_addr_in == FCC_ADDR_PAGE);
	wire logic [7:0] cmd = reg_wdata_in;
	wire logic [6:0] page_field = page_choice_q[FCC_PAGE_MSB:0];
	// write-protect option is only honoured from user code
	// RQ1 option ignored
	// RQ25 relaxed per access
	wire logic wp_block  = write_protect_opt_in && !debug_access_in;
	// sectors are 1/8th of the user area; page bits line up with the address check below
	wire logic [2:0] act_sector = page_field[FCC_SECT_MSB_A-FCC_PAGE_LSB_A:FCC_SECT_LSB_A-FCC_PAGE_LSB_A];
	// RQ2 protection ignored
	wire logic sector_locked = !debug_access_in && protect_q[act_sector];

	// RQ19 page compare
	function automatic logic in_page(input logic [15:0] a, input logic [6:0] p);
		in_page = (a[FCC_ADDR_MSB:FCC_PAGE_LSB_A] == p);
	endfunction : in_page

	// guard terms sit here because the state machine reads prog_ok
	wire logic in_rsvd  = (mem_addr_in >= FCC_USER_TOP) && (mem_addr_in < FCC_RSVD_TOP);
	// RQ9 RQ10 reserved region guard
	wire logic rsvd_ok  = !in_rsvd || fetch_reserved_in;
	// RQ3 debugger programs anywhere
	wire logic page_hit = debug_access_in || mass_ok_q || in_page(mem_addr_in, page_field);
	wire logic prog_ok  = mem_req_in && mem_wr_in && rsvd_ok && page_hit && !wp_block
		&& !(!debug_access_in && protect_q[mem_addr_in[FCC_SECT_MSB_A:FCC_SECT_LSB_A]]);

	// -----------------------------------------------------------------
	// command state machine
	// -----------------------------------------------------------------
	always_comb
	begin
		state_d       = state_q;
		page_choice_d = page_choice_q;
		protect_d     = protect_q;
		mass_ok_d     = mass_ok_q;
		pg_start_d    = 1'b0;
		ms_start_d    = 1'b0;
		if (cmd_wr)
		begin
			// RQ12 default relock
			state_d   = FCC_LOCKED;
			mass_ok_d = 1'b0;
			unique case (state_q)
				FCC_LOCKED:
				begin
					// RQ11 first byte
					if (cmd == FCC_CMD_UNLOCK1)
						state_d = FCC_FIRST;
					// RQ13 protect select
					else if (cmd == FCC_CMD_PROT_SEL)
						state_d = FCC_PROT;
				end
				FCC_FIRST:
				begin
					// RQ11 second byte; RQ5 debugger skips rewrite
					if (cmd == FCC_CMD_UNLOCK2)
						state_d = debug_access_in ? FCC_UNLOCKED : FCC_SECOND;
				end
				FCC_UNLOCKED:
				begin
					// RQ13 page erase of active page
					if (cmd == FCC_CMD_PAGE_ERS && !wp_block && !sector_locked)
					begin
						state_d    = FCC_PG_ERS;
						pg_start_d = 1'b1;
					end
					// RQ7 mass erase only from debugger
					else if (cmd == FCC_CMD_MASS_ERS && debug_access_in)
					begin
						state_d    = FCC_MS_ERS;
						ms_start_d = 1'b1;
						mass_ok_d  = 1'b1;
					end
				end
				FCC_PROT:
				begin
					if (cmd == FCC_CMD_PROT_SEL)
						state_d = FCC_PROT;
				end
				// second unlock and busy states: any command relocks
				FCC_SECOND, FCC_PROG, FCC_PG_ERS, FCC_MS_ERS:
				begin
				end
			endcase
		end
		else if (page_wr)
		begin
			unique case (state_q)
				FCC_PROT:
				begin
					// RQ4 debugger full write; RQ23 user only sets
					if (debug_access_in)
						protect_d = reg_wdata_in[SECTOR_BITS-1:0];
					else
						protect_d = protect_q | reg_wdata_in[SECTOR_BITS-1:0];
				end
				FCC_SECOND:
				begin
					// RQ22 rewrite must match
					state_d = (reg_wdata_in == page_choice_q) ? FCC_UNLOCKED : FCC_LOCKED;
				end
				FCC_UNLOCKED:
				begin
					// RQ6 debugger may change page while unlocked
					if (debug_access_in)
						page_choice_d = reg_wdata_in;
				end
				// RQ18 page choice target
				FCC_LOCKED, FCC_FIRST, FCC_PROG, FCC_PG_ERS, FCC_MS_ERS:
					page_choice_d = reg_wdata_in;
			endcase
		end
		else if (op_done_in)
		begin
			// RQ24 erase completion relocks
			if (state_q == FCC_PG_ERS || state_q == FCC_MS_ERS)
				state_d = FCC_LOCKED;
			else if (state_q == FCC_PROG)
				state_d = FCC_UNLOCKED;
		end
		else if (prog_ok && state_q == FCC_UNLOCKED)
			state_d = FCC_PROG;
	end

	// -----------------------------------------------------------------
	// memory guard
	// -----------------------------------------------------------------
	assign mem_grant_out = mem_req_in && rsvd_ok;
	assign mem_prog_out  = prog_ok && (state_q == FCC_UNLOCKED);
	// RQ20 information area mapping
	assign info_area_select_out = page_choice_q[FCC_INFO_BIT] && (mem_addr_in >= FCC_INFO_BASE);

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	// RQ21 reset values
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q       <= FCC_LOCKED;
			page_choice_q <= FCC_RST_BYTE;
			protect_q     <= '0;
			mass_ok_q     <= 1'b0;
			pg_start_q    <= 1'b0;
			ms_start_q    <= 1'b0;
		end
		else
		begin
			state_q       <= state_d;
			page_choice_q <= page_choice_d;
			protect_q     <= protect_d;
			mass_ok_q     <= mass_ok_d;
			pg_start_q    <= pg_start_d;
			ms_start_q    <= ms_start_d;
		end
	end

	// -----------------------------------------------------------------
	// status and read data
	// -----------------------------------------------------------------
	logic [5:0] state_code;
	// RQ15 RQ16 state field encoding
	always_comb
	begin
		unique case (state_q)
			FCC_LOCKED:   state_code = FCC_ST_LOCKED;
			FCC_FIRST:    state_code = FCC_ST_FIRST;
			FCC_SECOND:   state_code = FCC_ST_SECOND;
			FCC_UNLOCKED: state_code = FCC_ST_UNLOCKED;
			FCC_PROT:     state_code = FCC_ST_PROT;
			FCC_PROG:     state_code = FCC_ST_PROG;
			FCC_PG_ERS:   state_code = FCC_ST_PAGE_ERS;
			FCC_MS_ERS:   state_code = FCC_ST_MASS_ERS;
		endcase
	end

	// protect register reads back in the slot of page choice while selected
	wire logic [7:0] page_slot = (state_q == FCC_PROT) ? 8'(protect_q) : page_choice_q;
	// RQ14 RQ17 shared address and reserved bits
	assign reg_rdata_out = !reg_rd_in ? FCC_RST_BYTE :
		(reg_addr_in == FCC_ADDR_COMMAND) ? {FCC_RSVD_BITS, state_code} :
		(reg_addr_in == FCC_ADDR_PAGE) ? page_slot : FCC_RST_BYTE;

	assign sector_protect_out   = protect_q;
	assign page_erase_start_out = pg_start_q;
	assign mass_erase_start_out = ms_start_q;
	assign active_page_out      = page_field;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	AST_UNLOCK_ORDER: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ11
		(state_q == FCC_LOCKED && cmd_wr && cmd == FCC_CMD_UNLOCK1) |=> state_q == FCC_FIRST)
		else $error("first unlock byte not taken");
	AST_BAD_RELOCK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ12
		(state_q == FCC_FIRST && cmd_wr && cmd != FCC_CMD_UNLOCK2) |=> state_q == FCC_LOCKED)
		else $error("bad sequence did not relock");
	AST_MASS_USER: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ7
		(cmd_wr && !debug_access_in) |=> !ms_start_q)
		else $error("mass erase from user code");
	AST_PROT_SET_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ23
		(page_wr && !debug_access_in) |=> ((protect_q & $past(protect_q)) == $past(protect_q)))
		else $error("user cleared protection");
	AST_ERASE_DONE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ24
		(state_q == FCC_PG_ERS && op_done_in && !cmd_wr && !page_wr) |=> state_q == FCC_LOCKED)
		else $error("erase end did not relock");
	AST_RSVD_BLOCK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ10
		(mem_req_in && in_rsvd && !fetch_reserved_in) |-> !mem_grant_out && !mem_prog_out)
		else $error("user reached reserved area");
	AST_RSVD_BITS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ17
		reg_rdata_out[7:6] == FCC_RSVD_BITS || reg_addr_in != FCC_ADDR_COMMAND)
		else $error("reserved status bits set");
	AST_DBG_UNLOCK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ5
		(state_q == FCC_FIRST && cmd_wr && cmd == FCC_CMD_UNLOCK2 && debug_access_in)
		|=> state_q == FCC_UNLOCKED ##1 reg_rdata_out == {FCC_RSVD_BITS, FCC_ST_UNLOCKED} || !reg_rd_in
		|| reg_addr_in != FCC_ADDR_COMMAND || state_q != FCC_UNLOCKED)
		else $error("debugger unlock incomplete");
	AST_PAGE_MISMATCH: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ22
		(state_q == FCC_SECOND && page_wr && reg_wdata_in != page_choice_q) |=> state_q == FCC_LOCKED)
		else $error("page rewrite mismatch did not relock");
	AST_PAGE_ERASE_GO: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ13
		(state_q == FCC_UNLOCKED && cmd_wr && cmd == FCC_CMD_PAGE_ERS && !wp_block && !sector_locked)
		|=> page_erase_start_out && state_q == FCC_PG_ERS)
		else $error("page erase not started");

endmodule : fcc_flash_command_controller
`default_nettype wire

/* File: test/fcc_flash_array_model.sv */
// flash array stand-in that answers program and erase launches
`timescale 1ns/1ps
`default_nettype none
module fcc_flash_array_model (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	// launch and answer delay
	input  wire logic       start_in,
	input  wire logic [3:0] delay_in,
	// completion
	output logic            op_done_out
);
	logic [4:0] cnt_q;
	// done is a single cycle pulse, at least two cycles after launch
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_q       <= 5'h00;
			op_done_out <= 1'b0;
		end
		else
		begin
			op_done_out <= (cnt_q == 5'h01);
			if (start_in)
				cnt_q <= 5'(delay_in) + 5'h02;
			else if (cnt_q != 5'h00)
				cnt_q <= cnt_q - 5'h01;
		end
	end
endmodule : fcc_flash_array_model
`default_nettype wire

/* File: test/tb_flash_command_controller.sv */
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_controller;
	import fcc_pkg::*;
	logic        clk;
	logic        rst_n = 1'b0;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        dbg   = 1'b0;
	logic        fres  = 1'b0;
	logic        wpo   = 1'b0;
	logic        mreq  = 1'b0;
	logic        mwr   = 1'b0;
	logic [11:0] addr  = 12'h000;
	logic [7:0]  wdata = 8'h00;
	logic [15:0] maddr = 16'h0000;
	logic [2:0]  sel   = 3'h0;
	logic [3:0]  dly   = 4'h0;
	logic [31:0] seed  = 32'h63c2ac37;
	logic [6:0]  p;
	logic [7:0]  r;
	logic [7:0]  rdata, prot, flags, probe;
	logic [6:0]  apage;
	logic        grant, prog, info, pst, mst, done, start;
	logic [7:0]  expq[$];
	int          errors  = 0;
	int          n_tests = 0;
	assign flags = {1'b0, mst, pst, info, prog, grant, 2'h0};
	assign probe = (sel == 3'h0) ? rdata : (sel == 3'h1) ? prot : (sel == 3'h7) ? {1'b0, apage} : {7'h00, flags[sel]};
	assign start = pst | mst | (mreq & mwr & prog);
	fcc_flash_command_controller fcc_flash_command_controller_inst (
		.ref_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .debug_access_in(dbg), .fetch_reserved_in(fres),
		.write_protect_opt_in(wpo), .mem_req_in(mreq), .mem_wr_in(mwr), .mem_addr_in(maddr),
		.mem_grant_out(grant), .mem_prog_out(prog), .info_area_select_out(info), .sector_protect_out(prot),
		.op_done_in(done), .op_sector_in(3'h0), .page_erase_start_out(pst), .mass_erase_start_out(mst),
		.active_page_out(apage));
	fcc_flash_array_model fcc_flash_array_model_inst (
		.ref_clk_in(clk), .rst_n_in(rst_n), .start_in(start), .delay_in(dly), .op_done_out(done));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------
	// helpers
	// ----------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : cmp
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask : wreg
	// notes the expectation; the watcher compares it at the falling edge
	task automatic chk(input logic [2:0] s, input logic [7:0] e);
		sel = s;
		rd = (s == 3'h0);
		expq.push_back(e);
		@(posedge clk);
		#1;
	endtask : chk
	task automatic st(input logic [7:0] e);
		addr = FCC_ADDR_COMMAND;
		chk(3'h0, e);
	endtask : st
	task automatic unl(input logic [6:0] pg);
		wreg(FCC_ADDR_PAGE, {1'b0, pg});
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK1);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK2);
		if (!dbg)
			wreg(FCC_ADDR_PAGE, {1'b0, pg});
	endtask : unl
	// bounded wait for the array to finish, then a random answer delay next time
	task automatic wait_done();
		for (int i = 0; i < 64 && done !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1)
			errors++;
		@(posedge clk);
		#1;
		dly = 4'(rnd());
	endtask : wait_done
	always @(negedge clk)
		if (expq.size() > 0)
			cmp(probe, expq.pop_front());
	initial
	begin
		#100000;
		errors++;
		stop_test();
	end
	// ----------------
	// scenarios
	// ----------------
	initial
	begin
		p = 7'(rnd() % 13);
		r = 8'(rnd());
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		st(8'h00);
		addr = FCC_ADDR_PAGE;
		chk(3'h0, 8'h00);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK2);
		st(8'h00);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK1);
		st(8'h01);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK1);
		st(8'h00);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK1);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_UNLOCK2);
		st(8'h02);
		wreg(FCC_ADDR_PAGE, {1'b0, p + 7'h01});
		st(8'h00);
		unl(p);
		st(8'h03);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_MASS_ERS);
		chk(3'h6, 8'h00);
		st(8'h00);
		unl(p);
		chk(3'h7, {1'b0, p});
		mreq = 1'b1;
		mwr = 1'b1;
		maddr = {p + 7'h01, 9'(rnd())};
		chk(3'h3, 8'h00);
		maddr = {p, 9'(rnd())};
		chk(3'h3, 8'h01);
		mreq = 1'b0;
		mwr = 1'b0;
		st(8'h08);
		wait_done();
		st(8'h03);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_PAGE_ERS);
		chk(3'h5, 8'h01);
		st(8'h10);
		wait_done();
		st(8'h00);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_PROT_SEL);
		st(8'h04);
		wreg(FCC_ADDR_PAGE, r);
		chk(3'h1, r);
		wreg(FCC_ADDR_PAGE, 8'h00);
		chk(3'h1, r);
		wreg(FCC_ADDR_PAGE, 8'hff);
		chk(3'h1, 8'hff);
		wreg(FCC_ADDR_COMMAND, 8'h00);
		unl(p);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_PAGE_ERS);
		chk(3'h5, 8'h00);
		wreg(FCC_ADDR_COMMAND, 8'h00);
		dbg = 1'b1;
		wpo = 1'b1;
		unl(p + 7'h01);
		st(8'h03);
		wreg(FCC_ADDR_PAGE, {1'b0, p});
		chk(3'h0, {1'b0, p});
		mreq = 1'b1;
		mwr = 1'b1;
		maddr = {p + 7'h02, 9'(rnd())};
		chk(3'h3, 8'h01);
		mreq = 1'b0;
		mwr = 1'b0;
		wait_done();
		wreg(FCC_ADDR_COMMAND, FCC_CMD_PAGE_ERS);
		chk(3'h5, 8'h01);
		wait_done();
		unl(p);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_MASS_ERS);
		chk(3'h6, 8'h01);
		st(8'h20);
		wait_done();
		st(8'h00);
		wreg(FCC_ADDR_COMMAND, FCC_CMD_PROT_SEL);
		wreg(FCC_ADDR_PAGE, 8'h00);
		chk(3'h1, 8'h00);
		wreg(FCC_ADDR_COMMAND, 8'h00);
		dbg = 1'b0;
		unl(p);
		mreq = 1'b1;
		mwr = 1'b1;
		maddr = {p, 9'(rnd())};
		chk(3'h3, 8'h00);
		mwr = 1'b0;
		wpo = 1'b0;
		wreg(FCC_ADDR_COMMAND, 8'h00);
		maddr = FCC_USER_TOP + 16'(rnd() % 4096);
		chk(3'h2, 8'h00);
		fres = 1'b1;
		chk(3'h2, 8'h01);
		fres = 1'b0;
		maddr = 16'(rnd()) & 16'h1fff;
		chk(3'h2, 8'h01);
		wreg(FCC_ADDR_PAGE, 8'h80);
		maddr = FCC_INFO_BASE | 16'(rnd() % 512);
		chk(3'h4, 8'h01);
		wreg(FCC_ADDR_PAGE, 8'h00);
		chk(3'h4, 8'h00);
		mreq = 1'b0;
		stop_test();
	end
endmodule : tb_flash_command_controller
`default_nettype wire
